// ### rtl/xram_mem.sv
`timescale 1ns/1ps
`default_nettype none
module xram_mem
(
  // Clock
  input  wire logic                           ref_clk,
  // Write port
  input  wire logic                           wr_en,
  input  wire logic [xram_pkg::PTR_W-1:0]     wr_addr,
  input  wire logic [xram_pkg::DATA_W-1:0]    wr_data,
  // Read port
  input  wire logic [xram_pkg::PTR_W-1:0]     rd_addr,
  output var  logic [xram_pkg::DATA_W-1:0]    rd_data
);
  // No reset: contents are battery backed, not cleared
  logic [xram_pkg::DATA_W-1:0] mem_reg [xram_pkg::DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end
endmodule : xram_mem
`default_nettype wire

// ### rtl/xram_pkg.sv
package xram_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W  = 8;
  localparam int unsigned DEPTH  = 256;
  localparam logic [ADDR_W-1:0] OFS_POINTER   = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_DATA_PORT = 5'h13;
  localparam logic [PTR_W-1:0]  PTR_RESET     = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_LOWEST    = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_HIGHEST   = 8'hFF;
  localparam logic [PTR_W-1:0]  PTR_STEP      = 8'h01;
  localparam logic [DATA_W-1:0] DATA_RESET    = 8'h00;
endpackage : xram_pkg

// ### rtl/xram_window.sv
// What this block does
// - 256 bytes of extended RAM, 8-bit pointer covering 00h to FFh.
// - Two latches: one holds the RAM pointer, one the data byte.
// - Host write to offset 10h loads the pointer.
// - Host read of offset 13h returns byte at the pointer.
// - Host write to offset 13h stores byte at the pointer.
// - Without burst, repeated data-port accesses hit the same location.
// - Pointer auto-advances only while burst_increment_enable is one.
// - In burst, pointer increments at end of each data-port access only.
// - Pointer wraps from FFh back to 00h in burst mode.
`timescale 1ns/1ps
`default_nettype none
module xram_window
(
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           rst_n,
  // Host bus
  input  wire logic                           cs_n,
  input  wire logic                           rd_n,
  input  wire logic                           wr_n,
  input  wire logic [xram_pkg::ADDR_W-1:0]    addr,
  input  wire logic [xram_pkg::DATA_W-1:0]    data_in,
  output var  logic [xram_pkg::DATA_W-1:0]    data_out,
  output logic                                data_oe,
  // Control
  input  wire logic                           burst_increment_enable
);
  // ****************************************
  // Strobe synchronisers
  // ****************************************
  // Third stage only remembers the last level, for edge detect
  logic [2:0] sync1_reg, sync1_next;
  logic [2:0] sync2_reg, sync2_next;
  logic [2:0] sync3_reg, sync3_next;
  logic [xram_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [xram_pkg::DATA_W-1:0] din_reg, din_next;

  always_comb
  begin
    sync1_next = {cs_n, rd_n, wr_n};
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    addr_next  = addr;
    din_next   = data_in;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      sync3_reg <= 3'h7;
      addr_reg  <= '0;
      din_reg   <= xram_pkg::DATA_RESET;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      addr_reg  <= addr_next;
      din_reg   <= din_next;
    end
  end

  // ****************************************
  // Access decode
  // ****************************************
  // Access is live while chip select and one strobe are both low
  logic rd_act, wr_act, rd_was, wr_was, acc_end, rd_end;
  assign rd_act = !sync2_reg[2] && !sync2_reg[1];
  assign wr_act = !sync2_reg[2] && !sync2_reg[0];
  assign rd_was = !sync3_reg[2] && !sync3_reg[1];
  assign wr_was = !sync3_reg[2] && !sync3_reg[0];
  // Any strobe rising ends the access, exactly once
  assign acc_end = (rd_was && !rd_act) || (wr_was && !wr_act);
  assign rd_end  = rd_was && !rd_act;

  function automatic logic is_ofs(input logic [xram_pkg::ADDR_W-1:0] a,
                                  input logic [xram_pkg::ADDR_W-1:0] o);
    return a == o;
  endfunction

  // Wrap written out, not left to overflow, so intent survives resizing
  function automatic logic [xram_pkg::PTR_W-1:0] ptr_step(input logic [xram_pkg::PTR_W-1:0] p);
    if (p == xram_pkg::PTR_HIGHEST)
    begin
      return xram_pkg::PTR_LOWEST;
    end
    return p + xram_pkg::PTR_STEP;
  endfunction

  // ****************************************
  // Pointer and data latches
  // ****************************************
  logic [xram_pkg::PTR_W-1:0]  ptr_reg, ptr_next;
  logic [xram_pkg::DATA_W-1:0] data_reg, data_next;
  logic                        wr_done_reg, wr_done_next;
  logic                        mem_we;
  logic [xram_pkg::DATA_W-1:0] mem_rd;

  logic                        wr_first;
  logic                        burst_on, port_end, burst_step;

  // One commit per strobe, however long the host holds it low
  assign wr_first   = wr_act && !wr_done_reg;
  // Offset is the one latched for the access now ending
  assign port_end   = acc_end && is_ofs(addr_reg, xram_pkg::OFS_DATA_PORT);
  assign burst_on   = burst_increment_enable;
  assign burst_step = burst_on && port_end;

  // Write commits on the first synchronised cycle; pointer moves after
  assign mem_we = wr_first && is_ofs(addr_reg, xram_pkg::OFS_DATA_PORT);

  always_comb
  begin
    ptr_next     = ptr_reg;
    data_next    = data_reg;
    wr_done_next = wr_done_reg;
    if (wr_first)
    begin
      wr_done_next = 1'b1;
      if (is_ofs(addr_reg, xram_pkg::OFS_POINTER))
      begin
        ptr_next = din_reg;
      end
      else if (is_ofs(addr_reg, xram_pkg::OFS_DATA_PORT))
      begin
        data_next = din_reg;
      end
    end
    // Rearm once the strobe is seen high
    if (!wr_act)
    begin
      wr_done_next = 1'b0;
    end
    // Step lands after release, once the read data has been taken
    if (burst_step)
    begin
      ptr_next = ptr_step(ptr_reg);
    end
    if (rd_act && is_ofs(addr_reg, xram_pkg::OFS_DATA_PORT))
    begin
      data_next = mem_rd;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_reg     <= xram_pkg::PTR_RESET;
      data_reg    <= xram_pkg::DATA_RESET;
      wr_done_reg <= 1'b0;
    end
    else
    begin
      ptr_reg     <= ptr_next;
      data_reg    <= data_next;
      wr_done_reg <= wr_done_next;
    end
  end

  xram_mem u_mem
  (
    .ref_clk (ref_clk),
    .wr_en   (mem_we),
    .wr_addr (ptr_reg),
    .wr_data (din_reg),
    .rd_addr (ptr_reg),
    .rd_data (mem_rd)
  );

  // ****************************************
  // Read data
  // ****************************************
  logic [xram_pkg::DATA_W-1:0] dout_reg, dout_next;

  always_comb
  begin
    dout_next = dout_reg;
    if (rd_act && is_ofs(addr_reg, xram_pkg::OFS_POINTER))
    begin
      dout_next = ptr_reg;
    end
    else if (rd_act && is_ofs(addr_reg, xram_pkg::OFS_DATA_PORT))
    begin
      // Byte reaches the pins through the data latch, one cycle behind
      dout_next = data_reg;
    end
    else if (rd_act)
    begin
      dout_next = xram_pkg::DATA_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_reg <= xram_pkg::DATA_RESET;
    end
    else
    begin
      dout_reg <= dout_next;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************
  // Output held frozen across the increment at strobe release
  assign data_out = dout_reg;
  // One extra cycle of drive covers the host's hold time
  assign data_oe  = rd_act || rd_end;
endmodule : xram_window
`default_nettype wire

// ### tb/xram_host.sv
`timescale 1ns/1ps
`default_nettype none
module xram_host
(
  // Clock and answer
  input  wire logic       ref_clk,
  input  wire logic [7:0] data_out,
  // Bus drive
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [4:0] addr,
  output logic      [7:0] data_in
);
  // ****
  // Access sequencer
  // ****
  initial {cs_n, rd_n, wr_n, addr, data_in} = 16'hE000;
  // Gap of five lets the tail increment land first
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge ref_clk);
    {cs_n, rd_n, wr_n, addr, data_in} <= {1'b0, w, !w, a, d};
    repeat (6) @(posedge ref_clk);
    q = data_out;
    {cs_n, rd_n, wr_n, data_in} <= {3'b111, ~d};
    repeat (5) @(posedge ref_clk);
  endtask
endmodule // xram_host
`default_nettype wire

// ### tb/xram_properties.sv
`timescale 1ns/1ps
`default_nettype none
module xram_properties
(
  // Host bus
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] data_out,
  input wire logic       data_oe
);
  // ****
  // Bus checks
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_read_drives: assert property ((!cs_n && !rd_n)[*5] |-> data_oe)
    else $error("read not driven");
  a_idle_quiet: assert property (rd_n[*5] |-> !data_oe)
    else $error("drive while idle");
  a_desel_quiet: assert property (cs_n[*5] |-> !data_oe)
    else $error("drive unselected");
  a_oe_cause: assert property ($rose(data_oe) |-> !rd_n && !$past(rd_n))
    else $error("drive without read");
  a_oe_rise: assert property ($fell(rd_n) && !cs_n |-> ##[2:5] data_oe)
    else $error("drive late");
  a_oe_drop: assert property ($rose(rd_n) |-> ##[1:5] !data_oe)
    else $error("drive held");
  a_out_stands: assert property (rd_n[*6] |=> $stable(data_out))
    else $error("data moved idle");
  a_unmapped_zero: assert property
    ((!cs_n && !rd_n && addr != 5'h10 && addr != 5'h13)[*6] |-> data_out == 8'h00)
    else $error("unmapped not zero");
  c_port: cover property ((!cs_n && !rd_n && addr == 5'h13)[*5]);
  c_ptr: cover property ((!cs_n && !rd_n && addr == 5'h10)[*5]);
  c_oe: cover property ($rose(data_oe));
endmodule // xram_properties
`default_nettype wire

// ### tb/xram_window_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module xram_window_tb_top;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       burst_en = 1'b0;
  logic       cs_n, rd_n, wr_n, data_oe;
  logic [4:0] addr, u;
  logic [7:0] data_in, data_out, q, p, d;
  logic [7:0] mem [256];
  int         miscompares = 0;
  int         cmp_count = 0;
  // ****
  // Bench
  // ****
  always #5 ref_clk = ~ref_clk;
  xram_host i_host (.ref_clk(ref_clk), .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in));
  xram_window i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .burst_increment_enable(burst_en));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Expected pointer after n burst steps; byte arithmetic gives the wrap
  function automatic logic [7:0] ptr_after(input logic [7:0] s, input int n);
    return s + 8'(n);
  endfunction
  initial
  begin
    void'($urandom(5270));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    i_host.acc(1'b0, 5'h10, 8'h00, q);
    chk(q, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      p = (i == 0) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      u = 5'($urandom_range(15));
      i_host.acc(1'b1, 5'h10, p, q);
      i_host.acc(1'b1, 5'h13, d, q);
      i_host.acc(1'b1, u, ~d, q);
      i_host.acc(1'b0, 5'h13, 8'h00, q);
      chk(q, d);
      i_host.acc(1'b0, 5'h13, 8'h00, q);
      chk(q, d);
      i_host.acc(1'b0, u, 8'h00, q);
      chk(q, 8'h00);
      i_host.acc(1'b0, 5'h10, 8'h00, q);
      chk(q, p);
    end
    burst_en <= 1'b1;
    for (int n = 0; n < 2; n++)
    begin
      i_host.acc(1'b1, 5'h10, 8'hFD, q);
      for (int k = 0; k < 4; k++)
      begin
        p = ptr_after(8'hFD, k);
        if (n == 0)
          mem[p] = 8'($urandom);
        i_host.acc(n == 0, 5'h13, mem[p], q);
        if (n == 1)
          chk(q, mem[p]);
      end
      i_host.acc(1'b0, 5'h10, 8'h00, q);
      chk(q, ptr_after(8'hFD, 4));
    end
    i_host.acc(1'b0, 5'h10, 8'h00, q);
    chk(q, ptr_after(8'hFD, 4));
    // Pointer clears on a mid-run reset, RAM keeps its bytes
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    i_host.acc(1'b0, 5'h10, 8'h00, q);
    chk(q, xram_pkg::PTR_RESET);
    i_host.acc(1'b0, 5'h13, 8'h00, q);
    chk(q, mem[8'h00]);
    tally_and_finish();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // xram_window_tb_top
bind xram_window xram_properties i_props (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
  .rd_n(rd_n), .addr(addr), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire
